//--- design/lrdc_pkg.sv
// Purpose: Shared constants for lane receiver detect control
// Assumes: 250 MHz core clock
// Notes: Times in their own units, cycle counts derived here
package lrdc_pkg;
  localparam int CLK_MHZ = 250;
  localparam int NUM_LANES = 4;
  localparam int PROBE_PERIOD_MS = 12;
  localparam int PROBE_LIMIT_MS = 600;
  localparam int PROBE_PERIOD_CYC = PROBE_PERIOD_MS * 1000 * CLK_MHZ;
  localparam int PROBE_LIMIT_CNT = PROBE_LIMIT_MS / PROBE_PERIOD_MS;
  localparam int PROBE_SETTLE_CYC = 4;
  localparam int SYNC_STAGES = 3;
  localparam logic [3:0] LANES_RESET = 4'h0;
  typedef enum logic [3:0] {
    LRDC_OFF = 4'b0001,
    LRDC_WAIT = 4'b0010,
    LRDC_PROBE = 4'b0100,
    LRDC_DONE = 4'b1000
  } lrdc_state_e;
endpackage

//--- design/lrdc_sync.sv
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Input asynchronous to clk
// Notes: Output changes once stages two and three agree
`timescale 1ns/100ps
module lrdc_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic pinIn,
  output logic levelOut
);
  logic [2:0] stage_reg;

  // Stage one is read only by stage two
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stage_reg <= {3{RESET_VAL}};
    end else begin
      stage_reg <= {stage_reg[1:0], pinIn};
    end
  end

  // Accept a change only when the later stages agree
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      levelOut <= RESET_VAL;
    end else if (stage_reg[1] == stage_reg[2]) begin
      levelOut <= stage_reg[2];
    end
  end
endmodule // lrdc_sync

//--- design/lane_receiver_detect_control.sv
// Purpose: Per-lane receiver detection and termination control
// Assumes: Analog probe reports both output halves per lane
// Notes: Probe result sampled after a short settle window
`timescale 1ns/100ps
module lane_receiver_detect_control
  import lrdc_pkg::*;
#(
  parameter int LANES = lrdc_pkg::NUM_LANES,
  parameter int PROBE_CYC = lrdc_pkg::PROBE_PERIOD_CYC,
  parameter int PROBE_LIMIT = lrdc_pkg::PROBE_LIMIT_CNT
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic presence_n,
  input wire logic manual_detect_sel,
  input wire logic termination_select,
  input wire logic [LANES-1:0] loadPos,
  input wire logic [LANES-1:0] loadNeg,
  output logic [LANES-1:0] probeReq,
  output logic [LANES-1:0] termEnable,
  output logic [LANES-1:0] laneActive,
  output logic powerDown,
  output logic detectRunning
);
  import lrdc_pkg::*;

  initial begin
    if (LANES < 1 || LANES > 16 || PROBE_CYC < PROBE_SETTLE_CYC + 2 || PROBE_LIMIT < 1) begin
      $error("lane_receiver_detect_control: bad parameters");
    end
  end

  localparam int CW = $clog2(PROBE_CYC + 1);
  localparam int LW = $clog2(PROBE_LIMIT + 2);

  logic presN;
  logic manSel;
  logic termSel;
  logic presN_reg;
  logic termSel_reg;
  logic autoMode;
  logic restart;
  logic [CW-1:0] tick_reg;
  logic [LW-1:0] tries_reg;
  logic tickWrap;
  logic settleDone;
  logic limitHit;

  // Pins cross into clk domain
  lrdc_sync #(.RESET_VAL(1'b1)) uPres (.clk(clk), .resetn(resetn), .pinIn(presence_n),
    .levelOut(presN));
  lrdc_sync #(.RESET_VAL(1'b0)) uMan (.clk(clk), .resetn(resetn), .pinIn(manual_detect_sel),
    .levelOut(manSel));
  lrdc_sync #(.RESET_VAL(1'b0)) uSel (.clk(clk), .resetn(resetn), .pinIn(termination_select),
    .levelOut(termSel));

  // Previous synced values for edge detection
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      presN_reg <= 1'b1;
      termSel_reg <= 1'b0;
    end else begin
      presN_reg <= presN;
      termSel_reg <= termSel;
    end
  end

  assign autoMode = !presN && !manSel;
  // Restart on presence fall, or select rise in limited mode
  assign restart = (presN_reg && !presN)
    || (autoMode && termSel && !termSel_reg);

  // Shared 12 ms probe tick; all lanes probe together
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tick_reg <= '0;
    end else if (!autoMode || restart) begin
      tick_reg <= '0;
    end else if (tickWrap) begin
      tick_reg <= '0;
    end else begin
      tick_reg <= tick_reg + CW'(1);
    end
  end
  assign tickWrap = (tick_reg == CW'(PROBE_CYC - 1));
  assign settleDone = (tick_reg == CW'(PROBE_SETTLE_CYC));

  // Probe count for the time-limited mode
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tries_reg <= '0;
    end else if (!autoMode || restart) begin
      tries_reg <= '0;
    end else if (tickWrap && !limitHit) begin
      tries_reg <= tries_reg + LW'(1);
    end
  end
  assign limitHit = termSel && (tries_reg >= LW'(PROBE_LIMIT));

  // Per-lane state machine, each lane independent
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : gLane
      lrdc_state_e state_reg;
      logic bothLoaded;
      assign bothLoaded = loadPos[g] && loadNeg[g];

      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          state_reg <= LRDC_OFF;
        end else if (!autoMode || restart) begin
          state_reg <= autoMode ? LRDC_WAIT : LRDC_OFF;
        end else begin
          unique case (state_reg)
            LRDC_OFF: begin
              state_reg <= LRDC_WAIT;
            end
            LRDC_WAIT: begin
              // Probe at start of each period unless limit reached
              if (tick_reg == '0 && !limitHit) begin
                state_reg <= LRDC_PROBE;
              end
            end
            LRDC_PROBE: begin
              if (settleDone) begin
                state_reg <= bothLoaded ? LRDC_DONE : LRDC_WAIT;
              end
            end
            LRDC_DONE: begin
              state_reg <= LRDC_DONE;
            end
            default: begin
              state_reg <= LRDC_OFF;
            end
          endcase
        end
      end

      // Outputs registered from mode and lane state
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          probeReq[g] <= 1'b0;
          termEnable[g] <= 1'b0;
          laneActive[g] <= 1'b0;
        end else if (presN) begin
          // Power-down forces high-Z whatever the other pins say
          probeReq[g] <= 1'b0;
          termEnable[g] <= 1'b0;
          laneActive[g] <= 1'b0;
        end else if (manSel) begin
          probeReq[g] <= 1'b0;
          termEnable[g] <= termSel;
          laneActive[g] <= termSel;
        end else begin
          probeReq[g] <= (state_reg == LRDC_PROBE) && !restart;
          termEnable[g] <= (state_reg == LRDC_DONE) && !restart;
          laneActive[g] <= (state_reg == LRDC_DONE) && !restart;
        end
      end

      a_lane_term_mode: assert property (@(posedge clk) disable iff (!resetn)
        ($past(manSel) && !$past(presN)) |-> termEnable[g] == $past(termSel))
        else $error("manual termination mismatch");

      a_lane_hiz_auto: assert property (@(posedge clk) disable iff (!resetn)
        ($past(autoMode) && $past(state_reg) != LRDC_DONE) |-> !termEnable[g])
        else $error("termination before detection");

      a_lane_both_halves: assert property (@(posedge clk) disable iff (!resetn)
        (autoMode && !restart && state_reg == LRDC_PROBE && settleDone && !loadNeg[g])
        |=> state_reg != LRDC_DONE)
        else $error("detected with one half open");
    end
  endgenerate

  // Power-down and run status
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      powerDown <= 1'b1;
      detectRunning <= 1'b0;
    end else begin
      powerDown <= presN;
      detectRunning <= autoMode && !limitHit;
    end
  end

  a_auto_gate: assert property (@(posedge clk) disable iff (!resetn)
    !$past(autoMode) |-> probeReq == '0)
    else $error("probe outside automatic mode");
  a_pres_restart: assert property (@(posedge clk) disable iff (!resetn)
    (presN_reg && !presN && autoMode) |=> (tick_reg == '0 && tries_reg == '0))
    else $error("presence edge did not restart");
  a_period_wrap: assert property (@(posedge clk) disable iff (!resetn)
    (autoMode && !restart && tickWrap) |=> tick_reg == '0)
    else $error("probe period wrong");
  a_limit_stop: assert property (@(posedge clk) disable iff (!resetn)
    ($past(limitHit) && $past(autoMode) && !$past(restart)
      && $past(gLane[0].state_reg) == LRDC_WAIT) |-> gLane[0].state_reg != LRDC_PROBE)
    else $error("probing after limit");
  a_sel_restart: assert property (@(posedge clk) disable iff (!resetn)
    (autoMode && termSel && !termSel_reg) |=> tries_reg == '0)
    else $error("select pulse did not restart");
  a_man_idle: assert property (@(posedge clk) disable iff (!resetn)
    ($past(manSel) && !$past(presN) && !$past(termSel)) |-> laneActive == '0)
    else $error("manual idle not honoured");
  a_man_active: assert property (@(posedge clk) disable iff (!resetn)
    ($past(manSel) && !$past(presN) && $past(termSel)) |-> &laneActive)
    else $error("manual active not honoured");
  // Synced level may only take the value the last stage already held
  a_sync_edge: assert property (@(posedge clk) disable iff (!resetn)
    $changed(presN) |-> presN == $past(uPres.stage_reg[2]))
    else $error("edge not from synced value");

  c_auto_detect: cover property (@(posedge clk) disable iff (!resetn)
    autoMode ##1 termEnable[0]);
  c_limit_reached: cover property (@(posedge clk) disable iff (!resetn) limitHit);
  c_manual_on: cover property (@(posedge clk) disable iff (!resetn)
    manSel && !presN ##1 laneActive[0]);
  c_restart: cover property (@(posedge clk) disable iff (!resetn) restart);
endmodule // lane_receiver_detect_control

//--- verification/lrdc_load_model.sv
// Purpose: Downstream receiver load seen by each lane's probe
// Assumes: The probe result counts only while probeReq is high
// Notes: Outside a probe the lines toggle so stale values never help
`timescale 1ns/100ps
module lrdc_load_model #(
  parameter int LANES = 4
) (
  input wire logic clk,
  input wire logic [LANES-1:0] probeReq,
  input wire logic [LANES-1:0] posPresent,
  input wire logic [LANES-1:0] negPresent,
  output logic [LANES-1:0] loadPos,
  output logic [LANES-1:0] loadNeg
);
  logic junk_reg = 1'b0;
  // Free-running pattern for unprobed lanes
  always_ff @(posedge clk) begin
    junk_reg <= ~junk_reg;
  end
  // Each half reports its own load, lane by lane
  always_comb begin
    for (int i = 0; i < LANES; i++) begin
      loadPos[i] = probeReq[i] ? posPresent[i] : junk_reg;
      loadNeg[i] = probeReq[i] ? negPresent[i] : ~junk_reg;
    end
  end
endmodule // lrdc_load_model

//--- verification/testbench.sv
// Purpose: Self-checking bench for lane receiver detect control
// Assumes: Short probe period and limit parameters
// Notes: Bench acts as board controller, load model as far side
`timescale 1ns/100ps
module testbench;
  import lrdc_pkg::*;
  localparam int PER = 20;
  localparam int LIM = 3;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic presence_n = 1'b1;
  logic manual_detect_sel = 1'b0;
  logic termination_select = 1'b0;
  logic [3:0] posPresent = 4'h0;
  logic [3:0] negPresent = 4'h0;
  logic [3:0] loadPos, loadNeg, probeReq, termEnable, laneActive;
  logic powerDown, detectRunning;
  int n_fail = 0;
  int tests_run = 0;
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin n_fail++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
  lane_receiver_detect_control #(.LANES(4), .PROBE_CYC(PER), .PROBE_LIMIT(LIM))
    u_lane_receiver_detect_control (.clk(clk), .resetn(resetn), .presence_n(presence_n),
    .manual_detect_sel(manual_detect_sel), .termination_select(termination_select),
    .loadPos(loadPos), .loadNeg(loadNeg), .probeReq(probeReq), .termEnable(termEnable),
    .laneActive(laneActive), .powerDown(powerDown), .detectRunning(detectRunning));
  lrdc_load_model #(.LANES(4)) u_lrdc_load_model (.clk(clk), .probeReq(probeReq),
    .posPresent(posPresent), .negPresent(negPresent), .loadPos(loadPos), .loadNeg(loadNeg));
  // Free-running 250 MHz clock
  initial begin
    forever #2 clk = ~clk;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Bounded wait for a termination pattern
  task automatic wait_term(input logic [3:0] ex, input int bound);
    int k;
    for (k = 0; k < bound && termEnable !== ex; k++) step(1);
    `CHK("termEnable", ex, termEnable)
    if (termEnable !== ex) report_and_stop();
  endtask
  // Power down for 5 us, then present again
  task automatic restart();
    presence_n = 1'b1;
    step(1250);
    `CHK("powerDown", 1'b1, powerDown)
    `CHK("termEnable", 4'h0, termEnable)
    presence_n = 1'b0;
    step(5);
    `CHK("termEnable", 4'h0, termEnable)
    `CHK("powerDown", 1'b0, powerDown)
  endtask
  task automatic t_manual();
    presence_n = 1'b0;
    manual_detect_sel = 1'b1;
    step(8);
    `CHK("termEnable", 4'h0, termEnable)
    `CHK("laneActive", 4'h0, laneActive)
    termination_select = 1'b1;
    step(8);
    `CHK("termEnable", 4'hF, termEnable)
    `CHK("laneActive", 4'hF, laneActive)
    `CHK("detectRunning", 1'b0, detectRunning)
  endtask
  task automatic t_auto();
    manual_detect_sel = 1'b0;
    termination_select = 1'b0;
    posPresent = 4'h7;
    negPresent = 4'h3;
    restart();
    wait_term(4'h3, 2 * PER + 20);
    `CHK("laneActive", 4'h3, laneActive)
    posPresent = 4'hF;
    negPresent = 4'hB;
    wait_term(4'hB, 2 * PER + 20);
  endtask
  task automatic t_limited();
    int seen;
    termination_select = 1'b1;
    posPresent = 4'h0;
    negPresent = 4'h0;
    restart();
    `CHK("detectRunning", 1'b1, detectRunning)
    step(LIM * PER + 30);
    `CHK("detectRunning", 1'b0, detectRunning)
    posPresent = 4'hF;
    negPresent = 4'hF;
    seen = 0;
    repeat (3 * PER) begin
      step(1);
      seen += (probeReq != 4'h0);
    end
    `CHK("probes", 0, seen)
    `CHK("termEnable", 4'h0, termEnable)
    termination_select = 1'b0;
    step(6);
    termination_select = 1'b1;
    wait_term(4'hF, 2 * PER + 20);
  endtask
  task automatic report_and_stop();
    $display("checks %0d failures %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    step(5);
    resetn = 1'b1;
    step(1250);
    t_manual();
    t_auto();
    t_limited();
    report_and_stop();
  end
endmodule // testbench
